// ===== common/iro_res_pkg.sv
// Package of types and constants for the I/O read-to-owner collision resolver.
package iro_res_pkg;

  localparam int ADDR_W   = 34;
  localparam int GRAN_LSB = 5;   // Coherence granule is 32 bytes; low bits ignored in compares.
  localparam int ID_W     = 8;
  localparam int TID_W    = 8;
  localparam int NPART    = 16;  // Width of the participant mask.

  // Incoming shared-memory transaction kinds.
  typedef enum logic [4:0] {
    OP_READ_HOME, OP_IREAD_HOME, OP_READ_OWNER, OP_RTO_HOME, OP_RTO_OWNER,
    OP_DKILL_HOME, OP_DKILL_SHARER, OP_CASTOUT, OP_FLUSH,
    OP_IO_READ_HOME, OP_IO_READ_OWNER, OP_IKILL_SHARER,
    OP_TLBIE, OP_TLBSYNC, OP_IKILL_HOME, OP_OTHER
  } op_kind_t;

  typedef enum logic [1:0] {
    RSP_DONE, RSP_ERROR, RSP_PASS
  } rsp_kind_t;

  // One incoming request from the interconnect.
  typedef struct packed {
    op_kind_t           kind;
    logic [ADDR_W-1:0]  addr;
    logic [ID_W-1:0]    src_id;
    logic [TID_W-1:0]   tid;
  } in_req_t;

  // Response returned to the requestor; PASS means the normal path handles it.
  typedef struct packed {
    rsp_kind_t          kind;
    logic [ID_W-1:0]    dst_id;
    logic [TID_W-1:0]   tid;
  } rsp_t;

  // Request forwarded to the local processor.
  typedef struct packed {
    op_kind_t           kind;
    logic [ADDR_W-1:0]  addr;
  } fwd_t;

  // Sharer invalidate fan-out: one bit per participant to receive IKILL_SHARER.
  typedef struct packed {
    logic [NPART-1:0]   targets;
    logic [ADDR_W-1:0]  addr;
  } ikill_t;

endpackage : iro_res_pkg

// ===== core/iro_res.sv
// Collision resolver for a non-participant with an outstanding I/O read-to-owner.
`timescale 1ns/100ps
`default_nettype none

module iro_res (
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  // Own outstanding IO_READ_OWNER: issued and finally answered.
  input  wire logic                          iro_issue,
  input  wire logic [iro_res_pkg::ADDR_W-1:0] iro_addr,
  input  wire logic                          iro_final_rsp,
  // Participant set of the coherence domain.
  input  wire logic [iro_res_pkg::NPART-1:0]  part_mask,
  // Incoming request, taken when req_valid and req_ready.
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire iro_res_pkg::in_req_t          req,
  // Response towards the requestor.
  output logic                               rsp_valid,
  input  wire logic                          rsp_ready,
  output iro_res_pkg::rsp_t                  rsp,
  // Forward to the local processor; fwd_ack marks it completed.
  output logic                               fwd_valid,
  output iro_res_pkg::fwd_t                  fwd,
  input  wire logic                          fwd_ack,
  // Sharer invalidate fan-out.
  output logic                               ikill_valid,
  input  wire logic                          ikill_ready,
  output iro_res_pkg::ikill_t                ikill,
  output logic                               pending
);

  typedef enum logic [2:0] {ST_IDLE, ST_FWD, ST_IKILL, ST_RSP} state_t;

  state_t                          state_ff,    nxt_state;
  logic                            pend_ff,     nxt_pend;
  logic [iro_res_pkg::ADDR_W-1:0]  paddr_ff,    nxt_paddr;
  iro_res_pkg::rsp_t               rsp_ff,      nxt_rsp;
  iro_res_pkg::fwd_t               fwd_ff,      nxt_fwd;
  iro_res_pkg::ikill_t             ikill_ff,    nxt_ikill;
  logic                            rspv_ff,     nxt_rspv;

  // True when two addresses fall in the same coherence granule.
  function automatic logic same_gran(input logic [iro_res_pkg::ADDR_W-1:0] a,
                                     input logic [iro_res_pkg::ADDR_W-1:0] b);
    return a[iro_res_pkg::ADDR_W-1:iro_res_pkg::GRAN_LSB] == b[iro_res_pkg::ADDR_W-1:iro_res_pkg::GRAN_LSB];
  endfunction

  // True for kinds that are answered with ERROR on collision.
  function automatic logic err_kind(input iro_res_pkg::op_kind_t k);
    unique case (k)
      iro_res_pkg::OP_READ_HOME, iro_res_pkg::OP_IREAD_HOME, iro_res_pkg::OP_READ_OWNER,
      iro_res_pkg::OP_RTO_HOME, iro_res_pkg::OP_RTO_OWNER:          return 1'b1;
      iro_res_pkg::OP_DKILL_HOME, iro_res_pkg::OP_DKILL_SHARER,
      iro_res_pkg::OP_CASTOUT, iro_res_pkg::OP_FLUSH:               return 1'b1;
      iro_res_pkg::OP_IO_READ_HOME, iro_res_pkg::OP_IO_READ_OWNER,
      iro_res_pkg::OP_IKILL_SHARER:                                 return 1'b1;
      default:                                                      return 1'b0;
    endcase
  endfunction

  logic  take;
  logic  coll;
  logic  [iro_res_pkg::NPART-1:0] src_bit;

  assign req_ready   = (state_ff == ST_IDLE);
  assign take        = req_valid && req_ready;
  assign coll        = pend_ff && same_gran(req.addr, paddr_ff);
  assign src_bit     = (req.src_id < iro_res_pkg::ID_W'(iro_res_pkg::NPART))
                       ? iro_res_pkg::NPART'(1) << req.src_id[3:0] : '0;
  assign rsp_valid   = rspv_ff;
  assign rsp         = rsp_ff;
  assign fwd_valid   = (state_ff == ST_FWD);
  assign fwd         = fwd_ff;
  assign ikill_valid = (state_ff == ST_IKILL);
  assign ikill       = ikill_ff;
  assign pending     = pend_ff;

  // Tracks the outstanding request; a same-cycle issue wins over the final response and keeps it pending.
  always_comb begin
    nxt_pend  = pend_ff;
    nxt_paddr = paddr_ff;
    if (iro_final_rsp) begin
      nxt_pend = 1'b0;
    end
    if (iro_issue) begin
      nxt_pend  = 1'b1;
      nxt_paddr = iro_addr;
    end
  end

  // Sequencer for one incoming request.
  always_comb begin
    nxt_state = state_ff;
    nxt_rsp   = rsp_ff;
    nxt_fwd   = fwd_ff;
    nxt_ikill = ikill_ff;
    nxt_rspv  = rspv_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_rsp.dst_id = req.src_id;
          nxt_rsp.tid    = req.tid;
          nxt_fwd.kind   = req.kind;
          nxt_fwd.addr   = req.addr;
          nxt_ikill.addr = req.addr;
          nxt_ikill.targets = part_mask & ~src_bit;
          if (req.kind == iro_res_pkg::OP_TLBIE || req.kind == iro_res_pkg::OP_TLBSYNC) begin
            nxt_rsp.kind = iro_res_pkg::RSP_DONE;
            nxt_state    = ST_FWD;
          end else if (req.kind == iro_res_pkg::OP_IKILL_HOME) begin
            nxt_rsp.kind = iro_res_pkg::RSP_DONE;
            nxt_state    = ST_FWD;
          end else if (coll && err_kind(req.kind)) begin
            nxt_rsp.kind = iro_res_pkg::RSP_ERROR;
            nxt_rspv     = 1'b1;
            nxt_state    = ST_RSP;
          end else begin
            nxt_rsp.kind = iro_res_pkg::RSP_PASS;
            nxt_rspv     = 1'b1;
            nxt_state    = ST_RSP;
          end
        end
      end
      ST_FWD: begin
        if (fwd_ack) begin
          if (fwd_ff.kind == iro_res_pkg::OP_IKILL_HOME) begin
            nxt_state = ST_IKILL;
          end else begin
            nxt_rspv  = 1'b1;
            nxt_state = ST_RSP;
          end
        end
      end
      ST_IKILL: begin
        if (ikill_ready) begin
          nxt_rspv  = 1'b1;
          nxt_state = ST_RSP;
        end
      end
      ST_RSP: begin
        if (rsp_ready) begin
          nxt_rspv  = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // Registers all state.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      pend_ff  <= 1'b0;
      paddr_ff <= '0;
      rsp_ff   <= '0;
      fwd_ff   <= '0;
      ikill_ff <= '0;
      rspv_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pend_ff  <= nxt_pend;
      paddr_ff <= nxt_paddr;
      rsp_ff   <= nxt_rsp;
      fwd_ff   <= nxt_fwd;
      ikill_ff <= nxt_ikill;
      rspv_ff  <= nxt_rspv;
    end
  end

  // A sequence for the forward-then-answer path.
  sequence s_fwd_done;
    fwd_valid && fwd_ack ##1 rsp_valid && rsp.kind == iro_res_pkg::RSP_DONE;
  endsequence

  AST_ERR_ON_COLL: assert property (@(posedge core_clk) disable iff (srst)
    take && coll && err_kind(req.kind) |=> rsp_valid && rsp.kind == iro_res_pkg::RSP_ERROR)
    else $error("Colliding request did not get ERROR.");

  AST_NO_ERR_WITHOUT_COLL: assert property (@(posedge core_clk) disable iff (srst)
    take && !coll |=> rsp.kind != iro_res_pkg::RSP_ERROR)
    else $error("ERROR given without a collision.");

  AST_DKILL_ERR: assert property (@(posedge core_clk) disable iff (srst)
    take && coll && req.kind == iro_res_pkg::OP_DKILL_SHARER |=> rsp.kind == iro_res_pkg::RSP_ERROR)
    else $error("Colliding sharer kill not refused.");

  AST_IKS_ERR: assert property (@(posedge core_clk) disable iff (srst)
    take && coll && req.kind == iro_res_pkg::OP_IKILL_SHARER |=> rsp.kind == iro_res_pkg::RSP_ERROR)
    else $error("Colliding IKILL_SHARER not refused.");

  AST_TLB_FWD: assert property (@(posedge core_clk) disable iff (srst)
    take && (req.kind == iro_res_pkg::OP_TLBIE || req.kind == iro_res_pkg::OP_TLBSYNC)
    |=> fwd_valid && !rsp_valid)
    else $error("TLB operation not forwarded before answer.");

  AST_TLB_DONE: assert property (@(posedge core_clk) disable iff (srst)
    fwd_valid && fwd_ack && fwd.kind != iro_res_pkg::OP_IKILL_HOME |-> s_fwd_done)
    else $error("Forwarded operation not answered DONE.");

  // A requestor outside the participant range has no mask bit, so only in-range ids are checked.
  AST_IKILL_MASK: assert property (@(posedge core_clk) disable iff (srst)
    ikill_valid && rsp.dst_id < iro_res_pkg::ID_W'(iro_res_pkg::NPART)
    |-> (ikill.targets & (iro_res_pkg::NPART'(1) << rsp.dst_id[3:0])) == '0)
    else $error("Sharer invalidate sent back to requestor.");

  AST_IKILL_SEQ: assert property (@(posedge core_clk) disable iff (srst)
    fwd_valid && fwd_ack && fwd.kind == iro_res_pkg::OP_IKILL_HOME |=> ikill_valid && !rsp_valid)
    else $error("IKILL_HOME did not fan out invalidates.");

  AST_AFTER_FINAL: assert property (@(posedge core_clk) disable iff (srst)
    iro_final_rsp && !iro_issue |=> !pending)
    else $error("Resolution still active after final response.");

endmodule // iro_res

`default_nettype wire

// ===== tb/io_read_owner_collision_resolver_test.sv
// Self-checking testbench of the collision resolver with its far-side model.
`timescale 1ns/100ps
`default_nettype none
module io_read_owner_collision_resolver_test;
  localparam logic [33:0] A = 34'h2_1234_5680;
  logic                 core_clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 slow = 1'b0;
  logic                 iro_issue = 1'b0;
  logic [33:0]          iro_addr = 34'h0;
  logic                 iro_final_rsp = 1'b0;
  logic [15:0]          part_mask = 16'h00FF;
  logic                 req_valid = 1'b0;
  logic                 req_ready, rsp_valid, rsp_ready, fwd_valid, fwd_ack;
  logic                 ikill_valid, ikill_ready, pending;
  iro_res_pkg::in_req_t req = '0;
  iro_res_pkg::rsp_t    rsp, seen_rsp;
  iro_res_pkg::fwd_t    fwd, seen_fwd;
  iro_res_pkg::ikill_t  ikill, seen_ik;
  int                   fail_count = 0;
  int                   checks_done = 0;
  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;
  iro_res i_dut (.core_clk(core_clk), .srst(srst), .iro_issue(iro_issue), .iro_addr(iro_addr),
    .iro_final_rsp(iro_final_rsp), .part_mask(part_mask), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .fwd_valid(fwd_valid), .fwd(fwd),
    .fwd_ack(fwd_ack), .ikill_valid(ikill_valid), .ikill_ready(ikill_ready), .ikill(ikill), .pending(pending));
  iro_res_far i_far (.core_clk(core_clk), .srst(srst), .slow(slow), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .ikill_valid(ikill_valid), .ikill_ready(ikill_ready), .fwd_valid(fwd_valid),
    .fwd_ack(fwd_ack));
  task automatic finish_test();
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request is sent whole and its forward, fan-out and answer are captured.
  task automatic xfer(input iro_res_pkg::op_kind_t kd, input logic [33:0] ad, input logic [7:0] sid);
    int n;
    seen_fwd = '0;
    seen_ik  = '0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req       <= '{kind: kd, addr: ad, src_id: sid, tid: 8'h5A};
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (n = n; n < 100 && !(rsp_valid === 1'b1 && rsp_ready === 1'b1); n++) begin
      @(negedge core_clk);
      if (fwd_valid === 1'b1) seen_fwd = fwd;
      if (ikill_valid === 1'b1) seen_ik = ikill;
    end
    seen_rsp = rsp;
    if (n >= 100) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Own read-to-owner issue or final answer, one pulse each.
  task automatic pulse(input logic fin);
    @(posedge core_clk);
    iro_issue     <= !fin;
    iro_final_rsp <= fin;
    iro_addr      <= A;
    @(posedge core_clk);
    iro_issue     <= 1'b0;
    iro_final_rsp <= 1'b0;
  endtask
  // Before any issue a same-granule request is left to the normal path.
  task automatic s_idle();
    xfer(iro_res_pkg::OP_READ_HOME, A, 8'h05);
    chk(seen_rsp.kind, iro_res_pkg::RSP_PASS);
  endtask
  // Every colliding kind that must be refused gets ERROR, back to back.
  task automatic s_errors();
    pulse(1'b0);
    for (int i = 0; i < 12; i++) begin
      xfer(iro_res_pkg::op_kind_t'(i), A | 34'h1F, 8'h05);
      chk(seen_rsp.kind, iro_res_pkg::RSP_ERROR);
      chk(seen_rsp.dst_id, 8'h05);
      chk(seen_rsp.tid, 8'h5A);
    end
  endtask
  // A neighbouring granule does not collide, and an OTHER request in the same granule passes.
  task automatic s_granule();
    xfer(iro_res_pkg::OP_DKILL_HOME, A ^ 34'h20, 8'h05);
    chk(seen_rsp.kind, iro_res_pkg::RSP_PASS);
    xfer(iro_res_pkg::OP_OTHER, A, 8'h05);
    chk(seen_rsp.kind, iro_res_pkg::RSP_PASS);
  endtask
  // Both TLB kinds are forwarded and then answered DONE, with a slow far side.
  task automatic s_tlb();
    slow <= 1'b1;
    for (int i = 12; i < 14; i++) begin
      xfer(iro_res_pkg::op_kind_t'(i), A, 8'h05);
      chk(seen_fwd.kind, i);
      chk(seen_fwd.addr, A);
      chk(seen_rsp.kind, iro_res_pkg::RSP_DONE);
    end
  endtask
  // IKILL_HOME is forwarded and fanned out to all participants but the requestor.
  task automatic s_ikill();
    xfer(iro_res_pkg::OP_IKILL_HOME, A, 8'h03);
    chk(seen_fwd.kind, iro_res_pkg::OP_IKILL_HOME);
    chk(seen_ik.targets, 16'h00F7);
    chk(seen_ik.addr, A);
    chk(seen_rsp.kind, iro_res_pkg::RSP_DONE);
    chk(seen_rsp.dst_id, 8'h03);
    xfer(iro_res_pkg::OP_IKILL_HOME, A, 8'h13);
    chk(seen_ik.targets, 16'h00FF);
    chk(seen_rsp.kind, iro_res_pkg::RSP_DONE);
  endtask
  // After the final answer the granule is no longer resolved here.
  task automatic s_final();
    pulse(1'b1);
    @(negedge core_clk);
    chk(pending, 1'b0);
    xfer(iro_res_pkg::OP_READ_HOME, A, 8'h05);
    chk(seen_rsp.kind, iro_res_pkg::RSP_PASS);
  endtask
  // Reset for ten cycles, then the scenarios in turn.
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    s_idle();
    s_errors();
    s_granule();
    s_tlb();
    s_ikill();
    s_final();
    finish_test();
  end
endmodule // io_read_owner_collision_resolver_test
`default_nettype wire

// ===== tb/iro_res_far.sv
// Far-side model: end points taking answers and invalidates, plus the processor acknowledge.
`timescale 1ns/100ps
`default_nettype none
module iro_res_far (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic slow,
  input  wire logic rsp_valid,
  output logic      rsp_ready,
  input  wire logic ikill_valid,
  output logic      ikill_ready,
  input  wire logic fwd_valid,
  output logic      fwd_ack
);
  logic [1:0] wait_ff;
  logic       go;
  logic       any;
  // A request is accepted once the wait count is spent and no pulse is still out.
  assign go  = (wait_ff == 2'h0) && !(rsp_ready || ikill_ready || fwd_ack);
  assign any = rsp_valid || ikill_valid || fwd_valid;
  // Each acceptance is a one-cycle pulse; slow mode stalls the next acceptance.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_ff     <= 2'h0;
      rsp_ready   <= 1'b0;
      ikill_ready <= 1'b0;
      fwd_ack     <= 1'b0;
    end else begin
      rsp_ready   <= go && rsp_valid;
      ikill_ready <= go && ikill_valid;
      fwd_ack     <= go && fwd_valid;
      if (go && any) begin
        wait_ff <= slow ? 2'h3 : 2'h0;
      end else if (any && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule // iro_res_far
`default_nettype wire
